// ==== hw/isvm_ctrl.sv ====
// interrupt controller: per-source flags and enables, vector priorities, apb slave
`timescale 1ns/1ps
`include "isvm_map.svh"
module isvm_ctrl #(
    parameter logic [75:0] SRC_IMPL = `ISVM_SRC_IMPL
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [75:0]          src_req,
    output logic                      cpu_irq_req,
    output isvm_pkg::isvm_vec_t       cpu_vector,
    output isvm_pkg::isvm_prio_t      cpu_ripl,
    output logic                      irq
);
    import isvm_pkg::*;

    logic [31:0] pending_flag_reg   [`ISVM_NUM_FLAG_REG];
    logic [31:0] source_enable_reg  [`ISVM_NUM_FLAG_REG];
    logic [31:0] vector_priority_reg[`ISVM_NUM_PRIO_REG];
    logic        multi_vector_select;
    logic [75:0] req_prev;
    logic [75:0] flag_vec;
    logic [75:0] en_vec;
    logic        acc;
    logic        wr_go;
    logic [11:0] woff;
    logic [31:0] next_rdata;
    logic        next_err;
    logic        next_found;
    isvm_vec_t   next_vec;
    isvm_prio_t  next_prio;
    logic [4:0]  best_key;
    logic [75:0] set_vec;
    logic [75:0] clr_vec;

    // fixed source to vector table; shared entries are grouped peripherals
    function automatic isvm_vec_t isvm_vec_of(input int n);
        int v;
        v = 0;
        case (n)
            0, 1, 2, 3, 4: v = n;
            5, 6:          v = 5;
            7:             v = 6;
            8:             v = 7;
            9:             v = 8;
            10, 11:        v = 9;
            12:            v = 10;
            13:            v = 11;
            14:            v = 12;
            15, 16:        v = 13;
            17:            v = 14;
            18:            v = 15;
            19:            v = 16;
            20, 21:        v = 17;
            22:            v = 18;
            23:            v = 19;
            24:            v = 20;
            25, 26:        v = 21;
            27, 28, 29, 30, 31, 32, 33: v = n - 5;
            34:            v = 29;
            35, 36, 37:    v = 30;
            38, 39, 40:    v = 31;
            41, 42, 43:    v = 32;
            44, 45, 46, 47, 48, 49, 50: v = 33;
            51, 52:        v = 34;
            53, 54, 55:    v = 35;
            56, 57, 58:    v = 36;
            59, 60, 61:    v = 37;
            62, 63, 64:    v = 38;
            65, 66, 67:    v = 39;
            68, 69, 70:    v = 40;
            71:            v = 41;
            72, 73, 74, 75: v = n - 30;
            default:       v = 0;
        endcase
        return isvm_vec_t'(v);
    endfunction

    // level-held classes: capture, converter, usb, serial, two-wire, change, port, charge
    function automatic logic isvm_persistent(input int n);
        return (n == 5) || (n == 6) || (n == 10) || (n == 11) || (n == 15) || (n == 16) ||
               (n == 20) || (n == 21) || (n == 25) || (n == 26) || (n == 28) ||
               ((n >= 34) && (n <= 71));
    endfunction

    // bank word and bit that hold source n
    function automatic int word_of(input int n);
        return n / `ISVM_WORD_BITS;
    endfunction

    function automatic int bit_of(input int n);
        return n % `ISVM_WORD_BITS;
    endfunction

    // byte address of word k of a register bank
    function automatic logic [11:0] reg_addr(input logic [11:0] base, input int k);
        return base + 12'(`ISVM_WORD_BYTES * k);
    endfunction

    function automatic isvm_prio_t prio_of(input isvm_vec_t v);
        logic [31:0] w;
        w = vector_priority_reg[v[5:2]];
        return w[v[1:0] * `ISVM_VEC_FIELD_W + `ISVM_PRIO_LSB +: `ISVM_PRIO_W];
    endfunction

    function automatic isvm_sub_t sub_of(input isvm_vec_t v);
        logic [31:0] w;
        w = vector_priority_reg[v[5:2]];
        return w[v[1:0] * `ISVM_VEC_FIELD_W + `ISVM_SUB_LSB +: `ISVM_SUB_W];
    endfunction

    // flat views: request n lands at word n/32, bit n%32
    always_comb begin
        for (int n = 0; n < `ISVM_NUM_SRC; n++) begin
            flag_vec[n] = pending_flag_reg[word_of(n)][bit_of(n)];
            en_vec[n]   = source_enable_reg[word_of(n)][bit_of(n)];
        end
    end

    // a refused write still answers, with pslverr, but touches no register
    assign acc   = psel && penable && !pready;
    assign wr_go = acc && pwrite && !next_err;
    assign woff  = paddr;

    // apb answers one cycle into the access phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc && next_err;
            prdata  <= (acc && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b1;
        for (int k = 0; k < `ISVM_NUM_FLAG_REG; k++) begin
            if (paddr == reg_addr(`ISVM_OFS_FLAG, k)) begin
                next_rdata = pending_flag_reg[k];
                next_err   = 1'b0;
            end
            if (paddr == reg_addr(`ISVM_OFS_ENABLE, k)) begin
                next_rdata = source_enable_reg[k];
                next_err   = 1'b0;
            end
        end
        for (int k = 0; k < `ISVM_NUM_PRIO_REG; k++) begin
            if (paddr == reg_addr(`ISVM_OFS_PRIO, k)) begin
                next_rdata = vector_priority_reg[k];
                next_err   = 1'b0;
            end
        end
        if (paddr == `ISVM_OFS_CTRL) begin
            next_rdata[`ISVM_MULTI_VECTOR_SELECT_BIT] = multi_vector_select;
            next_err = 1'b0;
        end
        if (paddr == `ISVM_OFS_STAT) begin
            next_rdata[`ISVM_STAT_VEC_LSB +: $bits(isvm_vec_t)] = cpu_vector;
            next_rdata[`ISVM_STAT_RIPL_LSB +: `ISVM_PRIO_W] = cpu_ripl;
            next_err = 1'b0;
        end
    end

    // event capture; a set in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_prev <= '0;
        end else begin
            req_prev <= src_req;
        end
    end

    // edge sources set once per rising edge, level sources every cycle they stay high
    always_comb begin
        for (int n = 0; n < `ISVM_NUM_SRC; n++) begin
            set_vec[n] = isvm_persistent(n) ? src_req[n]
                                            : (src_req[n] && !req_prev[n]);
            clr_vec[n] = wr_go && (woff == reg_addr(`ISVM_OFS_FLAG, word_of(n)))
                         && pwdata[bit_of(n)];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < `ISVM_NUM_FLAG_REG; k++) begin
                pending_flag_reg[k] <= 32'h0000_0000;
            end
        end else begin
            for (int n = 0; n < `ISVM_NUM_SRC; n++) begin
                if (!SRC_IMPL[n]) begin
                    pending_flag_reg[word_of(n)][bit_of(n)] <= 1'b0;
                end else if (set_vec[n]) begin
                    pending_flag_reg[word_of(n)][bit_of(n)] <= 1'b1;
                end else if (clr_vec[n]) begin
                    pending_flag_reg[word_of(n)][bit_of(n)] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < `ISVM_NUM_FLAG_REG; k++) begin
                source_enable_reg[k] <= 32'h0000_0000;
            end
        end else begin
            for (int k = 0; k < `ISVM_NUM_FLAG_REG; k++) begin
                if (wr_go && woff == reg_addr(`ISVM_OFS_ENABLE, k)) begin
                    // bits past the last source stay zero so reads show no phantom enables
                    for (int b = 0; b < `ISVM_WORD_BITS; b++) begin
                        source_enable_reg[k][b] <= pwdata[b]
                            && (`ISVM_WORD_BITS * k + b < `ISVM_NUM_SRC)
                            && SRC_IMPL[(`ISVM_WORD_BITS * k + b) % `ISVM_NUM_SRC];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < `ISVM_NUM_PRIO_REG; k++) begin
                vector_priority_reg[k] <= 32'h0000_0000;
            end
        end else begin
            for (int k = 0; k < `ISVM_NUM_PRIO_REG; k++) begin
                if (wr_go && woff == reg_addr(`ISVM_OFS_PRIO, k)) begin
                    // vectors 46 and 47 of the last word do not exist
                    vector_priority_reg[k] <= pwdata & `ISVM_PRIO_MASK
                        & ((k == `ISVM_NUM_PRIO_REG - 1) ? `ISVM_LAST_PRIO_MASK
                                                        : 32'hffff_ffff);
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            multi_vector_select <= 1'b0;
        end else if (wr_go && woff == `ISVM_OFS_CTRL) begin
            multi_vector_select <= pwdata[`ISVM_MULTI_VECTOR_SELECT_BIT];
        end
    end

    // ascending scan with strict compare keeps the lower request on a tie
    always_comb begin
        next_found = 1'b0;
        next_vec   = `ISVM_SINGLE_VEC;
        next_prio  = 3'h0;
        best_key   = 5'h00;
        for (int n = 0; n < `ISVM_NUM_SRC; n++) begin
            isvm_vec_t v;
            logic [4:0] key;
            v   = isvm_vec_of(n);
            key = {prio_of(v), sub_of(v)};
            if (flag_vec[n] && en_vec[n] && SRC_IMPL[n] && prio_of(v) != 3'h0
                && (!next_found || key > best_key)) begin
                next_found = 1'b1;
                best_key   = key;
                next_vec   = v;
                next_prio  = prio_of(v);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_irq_req <= 1'b0;
            cpu_vector  <= `ISVM_SINGLE_VEC;
            cpu_ripl    <= 3'h0;
        end else begin
            cpu_irq_req <= next_found;
            cpu_ripl    <= next_prio;
            cpu_vector  <= multi_vector_select ? next_vec : `ISVM_SINGLE_VEC;
        end
    end

    // summary line ignores priority, so a source parked at priority zero still shows
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_vec & en_vec & SRC_IMPL);
        end
    end
endmodule // isvm_ctrl

// ==== hw/isvm_map.svh ====
// register offsets, field positions and counts of the source-to-vector interrupt map
// Function
// - 76 request lines 0..75 map onto vectors 0..45, several may share one.
// - natural order ranks request 0 highest, request 75 lowest.
// - flag of request n sits at bit n mod 32 of flag register n div 32.
// - enable bit sits at the same register index and bit as the flag.
// - each vector has 3-bit priority, 2-bit subpriority, four vectors per register.
// - requests sharing a vector share its priority and subpriority fields.
// - port change requests 44..50 all map to vector 33.
// - listed peripheral classes are persistent; core, timer and similar are not.
// - the four transfer channels own vectors 42..45 and are not persistent.
// - variants lacking a peripheral leave its flag and enable inactive.
// - a flag reads one when its request occurred, zero otherwise.
// - a control bit selects one shared vector or per-source vectors.
`ifndef ISVM_MAP_SVH
`define ISVM_MAP_SVH
`define ISVM_NUM_SRC       76
`define ISVM_NUM_VEC       46
`define ISVM_NUM_FLAG_REG  3
`define ISVM_NUM_PRIO_REG  12
`define ISVM_OFS_FLAG      12'h000
`define ISVM_OFS_ENABLE    12'h010
`define ISVM_OFS_PRIO      12'h020
`define ISVM_OFS_CTRL      12'h060
`define ISVM_OFS_STAT      12'h064
`define ISVM_PRIO_MASK     32'h1f1f1f1f
`define ISVM_PRIO_LSB      2
`define ISVM_SUB_LSB       0
`define ISVM_VEC_FIELD_W   8
`define ISVM_MULTI_VECTOR_SELECT_BIT      12
`define ISVM_STAT_RIPL_LSB 8
`define ISVM_SINGLE_VEC    6'h00
`define ISVM_SRC_IMPL      76'hfff_ffffffff_ffffffff
`define ISVM_WORD_BITS     32
`define ISVM_WORD_BYTES    4
`define ISVM_PRIO_W        3
`define ISVM_SUB_W         2
`define ISVM_STAT_VEC_LSB  0
`define ISVM_LAST_PRIO_MASK 32'h0000ffff
`endif

// ==== hw/isvm_pkg.sv ====
// types shared by the source-to-vector interrupt map and its checkers
package isvm_pkg;
    typedef logic [5:0] isvm_vec_t;
    typedef logic [2:0] isvm_prio_t;
    typedef logic [1:0] isvm_sub_t;
endpackage

// ==== sim/interrupt_source_vector_map_tb_top.sv ====
// self-checking bench for the interrupt map controller
`timescale 1ns/1ps
module interrupt_source_vector_map_tb_top;
    import isvm_pkg::*;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, cpu_irq_req, irq;
    isvm_vec_t   cpu_vector;
    isvm_prio_t  cpu_ripl;
    logic [75:0] src_req, ev = 0, lvl = 0;
    logic [32:0] exp_q[$];
    int          num_errors = 0, n_checks = 0, k, n;
    int          src_tab[8] = '{0, 6, 11, 37, 46, 55, 64, 75};
    int          vec_tab[8] = '{0, 5, 9, 30, 33, 35, 38, 45};
    always #2.5 core_clk = ~core_clk;
    isvm_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req(src_req), .cpu_irq_req(cpu_irq_req),
        .cpu_vector(cpu_vector), .cpu_ripl(cpu_ripl), .irq(irq));
    isvm_src_model u_src (.core_clk(core_clk), .rst(rst), .ev(ev), .lvl(lvl), .src_req(src_req));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // the expected answer is queued here and compared by the monitor
    task apb(input logic w, input int a, input logic [31:0] d, input logic [32:0] e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(a);
        pwdata <= d;
        exp_q.push_back(e);
        @(posedge core_clk);
        penable <= 1'b1;
        @(negedge core_clk);
        while (pready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(negedge core_clk) if (pready === 1'b1)
        check({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 'x);
    task settle;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task fire(input logic [75:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 76'h0;
        settle;
    endtask
    task clr;
        for (int i = 0; i < 3; i++) apb(1, 4 * i, '1, 0);
    endtask
    initial begin
        void'($urandom(93));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // reset values, with the holes of the map refused
        for (k = 0; k < 28; k++)
            apb(0, 4 * k, 0, {!(k < 3 || (k > 3 && k < 7) || (k > 7 && k < 20) || k > 23 && k < 26), 32'h0});
        for (k = 0; k < 3; k++) begin
            r = $urandom;
            apb(1, 16 + 4 * k, r, 0);
            apb(0, 16 + 4 * k, 0, {1'b0, k == 2 ? r & 32'hfff : r});
        end
        for (k = 0; k < 12; k++) begin
            apb(1, 32 + 4 * k, '1, 0);
            apb(0, 32 + 4 * k, 0, {1'b0, k == 11 ? 32'h1f1f : 32'h1f1f1f1f});
        end
        apb(1, 12'h01c, '1, {1'b1, 32'h0});
        apb(1, 12'h064, '1, 0);
        apb(0, 12'h064, 0, 0);
        $display("test registers done");
        for (k = 0; k < 3; k++) apb(1, 16 + 4 * k, '1, 0);
        apb(1, 12'h060, 32'h1000, 0);
        for (k = 0; k < 8; k++) begin
            n = src_tab[k];
            fire(76'h1 << n);
            check({irq, cpu_irq_req, cpu_ripl, cpu_vector}, {5'h1f, 6'(vec_tab[k])});
            apb(1, 4 * (n / 32), 0, 0);
            apb(0, 4 * (n / 32), 0, {1'b0, 32'h1 << (n % 32)});
            clr;
        end
        $display("test vector map done");
        fire((76'h1 << 75) | (76'h1 << 44));
        check(cpu_vector, 6'd33);
        apb(1, 12'h060, 0, 0);
        settle;
        check(cpu_vector, 6'h0);
        apb(1, 12'h060, 32'h1000, 0);
        apb(1, 12'h040, 32'h1f1f041f, 0);
        apb(1, 12'h04c, 32'h0000051f, 0);
        settle;
        check({cpu_ripl, cpu_vector}, {3'h1, 6'd45});
        apb(0, 12'h064, 0, {1'b0, 32'h0000012d});
        apb(1, 12'h040, 32'h1f1f001f, 0);
        apb(1, 12'h018, 0, 0);
        settle;
        check({irq, cpu_irq_req}, 2'b10);
        $display("test arbitration done");
        lvl <= (76'h1 << 46) | (76'h1 << 75);
        settle;
        clr;
        settle;
        apb(0, 4, 0, {1'b0, 32'h4000});
        apb(0, 8, 0, 0);
        lvl <= 76'h0;
        settle;
        clr;
        apb(0, 4, 0, 0);
        $display("test persistence done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, 12'h010, 0, 0);
        apb(0, 12'h060, 0, 0);
        settle;
        check({irq, cpu_irq_req}, 2'b00);
        $display("test reset done");
        summarize;
    end
    initial begin
        #100000;
        num_errors++;
        summarize;
    end
endmodule // interrupt_source_vector_map_tb_top

// ==== sim/isvm_ctrl_sva.sv ====
// port checker for the interrupt map controller
`timescale 1ns/1ps
module isvm_ctrl_sva
    import isvm_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 cpu_irq_req,
    input wire isvm_pkg::isvm_vec_t  cpu_vector,
    input wire isvm_pkg::isvm_prio_t cpu_ripl,
    input wire logic                 irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_access_len: assert property (psel && penable && !pready |=> pready)
        else $error("access not two cycles");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_req_flagged: assert property (cpu_irq_req |-> irq)
        else $error("request without flag");
    a_ripl_live: assert property (cpu_irq_req |-> cpu_ripl != 3'h0)
        else $error("zero priority presented");
    a_ripl_idle: assert property (!cpu_irq_req |-> cpu_ripl == 3'h0)
        else $error("priority without request");
    a_vec_range: assert property (cpu_vector <= 6'h2d) else $error("vector out of range");
    c_err: cover property (pready && pslverr);
    c_req: cover property (cpu_irq_req);
    c_masked: cover property (irq && !cpu_irq_req);
endmodule // isvm_ctrl_sva
bind isvm_ctrl isvm_ctrl_sva u_sva (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_ripl(cpu_ripl), .irq(irq));

// ==== sim/isvm_src_model.sv ====
// peripheral request lines feeding the controller
`timescale 1ns/1ps
module isvm_src_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [75:0] ev,
    input  wire logic [75:0] lvl,
    output logic      [75:0] src_req
);
    // events last one cycle; held conditions stay until dropped
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_req <= 76'h0;
        end else begin
            src_req <= ev | lvl;
        end
    end
endmodule // isvm_src_model
